// ### tsync_timer.sv
// timer with master/slave trigger logic and buffered capture/compare register
module tsync_timer #(
  parameter logic [7:0] PSC_DIV = tsync_pkg::PSC_DIV_RST
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // avalon-mm slave
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // link to other timer and channel pin
  input wire logic i_internal_trigger_in,
  input wire logic i_channel1_input,
  output logic o_trigger_output,
  output logic o_compare_output
);
  logic [2:0] master_select_field_reg;
  logic [2:0] slave_behaviour_select_reg;
  logic [2:0] trigger_source_select_reg;
  logic master_slave_align_bit_reg;
  logic counter_enable_bit_reg;
  logic trigger_flag_reg;
  logic [1:0] channel_direction_select_reg;
  logic [15:0] count_reg;
  logic [7:0] psc_reg;
  logic [15:0] preload_reg;
  logic [15:0] shadow_reg;
  logic shadow_blocked_reg;
  logic read_frozen_reg;
  logic [15:0] capture_pend_reg;
  logic capture_pend_valid_reg;
  logic compare1_reference_reg;
  logic [1:0] itr_sync_reg;
  logic [1:0] ch1_sync_reg;
  logic itr_prev_reg;
  logic ch1_prev_reg;
  logic count_enable_signal_dly_reg;
  logic update_event_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  logic access;
  logic wr;
  logic rd;
  logic trig_level;
  logic trig_prev;
  logic trig_rise;
  logic count_enable_signal;
  logic prescaler_clock;
  logic psc_wrap;
  logic tick;
  logic update_event;
  logic ug_write;
  logic input_mode;
  logic capture_strobe;
  logic freeze_now;

  // one wait state: read data latched in the first cycle, writes land on the second edge
  assign o_waitrequest = (i_read | i_write) & ~ack_reg;
  assign access = (i_read | i_write) & ack_reg;
  assign wr = i_write & access;
  assign rd = i_read & ~ack_reg;
  // high byte read freezes the preload in the cycle its data is latched
  assign freeze_now = read_frozen_reg | (rd && i_address == tsync_pkg::OFF_CCRH);
  assign ug_write = wr && i_address == tsync_pkg::OFF_CTRL && i_writedata[tsync_pkg::CTRL_UG];
  assign input_mode = channel_direction_select_reg != tsync_pkg::DIR_OUTPUT;

  // triggers pass two flops before use
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      itr_sync_reg <= 2'h0;
      ch1_sync_reg <= 2'h0;
      itr_prev_reg <= 1'b0;
      ch1_prev_reg <= 1'b0;
    end else begin
      itr_sync_reg <= {itr_sync_reg[0], i_internal_trigger_in};
      ch1_sync_reg <= {ch1_sync_reg[0], i_channel1_input};
      itr_prev_reg <= itr_sync_reg[1];
      ch1_prev_reg <= ch1_sync_reg[1];
    end
  end

  always_comb begin
    trig_level = 1'b0;
    trig_prev = 1'b0;
    if (trigger_source_select_reg == tsync_pkg::TS_CH1) begin
      trig_level = ch1_sync_reg[1];
      trig_prev = ch1_prev_reg;
    end else if (trigger_source_select_reg == tsync_pkg::TS_INTERNAL) begin
      trig_level = itr_sync_reg[1];
      trig_prev = itr_prev_reg;
    end
  end
  assign trig_rise = trig_level & ~trig_prev;

  // gating touches enable only; the clock stays local
  assign count_enable_signal = counter_enable_bit_reg &
    (slave_behaviour_select_reg != tsync_pkg::SMS_GATED || trig_level);
  // align bit holds prescaler one cycle behind enable so a chained slave lines up
  assign prescaler_clock = master_slave_align_bit_reg ?
    (count_enable_signal & count_enable_signal_dly_reg) : count_enable_signal;
  assign psc_wrap = psc_reg == PSC_DIV;
  assign tick = (slave_behaviour_select_reg == tsync_pkg::SMS_EXTCLK) ?
    (counter_enable_bit_reg & trig_rise) : (prescaler_clock & psc_wrap);
  assign update_event = (tick && count_reg == 16'hffff) || ug_write;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      count_enable_signal_dly_reg <= 1'b0;
      update_event_reg <= 1'b0;
    end else begin
      count_enable_signal_dly_reg <= count_enable_signal;
      update_event_reg <= update_event;
    end
  end

  // configuration and enable
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      master_select_field_reg <= 3'h0;
      slave_behaviour_select_reg <= 3'h0;
      trigger_source_select_reg <= 3'h0;
      master_slave_align_bit_reg <= 1'b0;
      channel_direction_select_reg <= 2'h0;
      compare1_reference_reg <= 1'b0;
      counter_enable_bit_reg <= 1'b0;
    end else begin
      if (wr && i_address == tsync_pkg::OFF_CTRL) begin
        master_select_field_reg <= i_writedata[tsync_pkg::CTRL_MMS_LO +: 3];
        counter_enable_bit_reg <= i_writedata[tsync_pkg::CTRL_CEN];
      end
      if (wr && i_address == tsync_pkg::OFF_SLAVE) begin
        slave_behaviour_select_reg <= i_writedata[tsync_pkg::SLV_SMS_LO +: 3];
        trigger_source_select_reg <= i_writedata[tsync_pkg::SLV_TS_LO +: 3];
        master_slave_align_bit_reg <= i_writedata[tsync_pkg::SLV_MSM];
      end
      if (wr && i_address == tsync_pkg::OFF_CHAN) begin
        channel_direction_select_reg <= i_writedata[tsync_pkg::CHAN_DIR_LO +: 2];
      end
      // trigger start wins over a same-cycle software write
      if (slave_behaviour_select_reg == tsync_pkg::SMS_TRIGGER && trig_rise) begin
        counter_enable_bit_reg <= 1'b1;
      end
      // compare reference: high in output mode while count below compare shadow
      compare1_reference_reg <= !input_mode && (count_reg < shadow_reg);
    end
  end

  // trigger flag: set on any slave-mode trigger action, cleared by writing 0
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      trigger_flag_reg <= 1'b0;
    end else if (slave_behaviour_select_reg[2] && trig_level != trig_prev &&
                 (trig_rise || slave_behaviour_select_reg == tsync_pkg::SMS_GATED)) begin
      trigger_flag_reg <= 1'b1;
    end else if (wr && i_address == tsync_pkg::OFF_STAT && !i_writedata[tsync_pkg::STAT_TIF]) begin
      trigger_flag_reg <= 1'b0;
    end
  end

  // counter and prescaler
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      count_reg <= tsync_pkg::CNT_RST;
      psc_reg <= 8'h00;
    end else if (ug_write) begin
      count_reg <= tsync_pkg::CNT_RST;
      psc_reg <= 8'h00;
    end else begin
      if (prescaler_clock) begin
        psc_reg <= psc_wrap ? 8'h00 : psc_reg + 8'h01;
      end
      if (wr && i_address == tsync_pkg::OFF_CNTH) begin
        count_reg[15:8] <= i_writedata[7:0];
      end else if (wr && i_address == tsync_pkg::OFF_CNTL) begin
        count_reg[7:0] <= i_writedata[7:0];
      end else if (tick) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // trigger output selection
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_trigger_output <= 1'b0;
    end else begin
      unique case (master_select_field_reg)
        tsync_pkg::MMS_ENABLE: o_trigger_output <= count_enable_signal;
        tsync_pkg::MMS_UPDATE: o_trigger_output <= update_event;
        default: o_trigger_output <= master_select_field_reg[2] &
                                     compare1_reference_reg;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_compare_output <= 1'b0;
    end else begin
      o_compare_output <= compare1_reference_reg;
    end
  end

  // capture on selected channel 1 rising edge in input mode
  assign capture_strobe = input_mode && ch1_sync_reg[1] && !ch1_prev_reg;

  // capture/compare buffering
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      preload_reg <= tsync_pkg::CCR_RST;
      shadow_reg <= tsync_pkg::CCR_RST;
      shadow_blocked_reg <= 1'b0;
      read_frozen_reg <= 1'b0;
      capture_pend_reg <= tsync_pkg::CCR_RST;
      capture_pend_valid_reg <= 1'b0;
    end else if (input_mode) begin
      shadow_blocked_reg <= 1'b0;
      if (capture_strobe) begin
        shadow_reg <= count_reg;
        capture_pend_reg <= count_reg;
      end
      // high byte read freezes preload until low byte read
      if (rd && i_address == tsync_pkg::OFF_CCRH) begin
        read_frozen_reg <= 1'b1;
      end else if (rd && i_address == tsync_pkg::OFF_CCRL) begin
        read_frozen_reg <= 1'b0;
      end
      if (capture_strobe && !freeze_now) begin
        preload_reg <= count_reg;
        capture_pend_valid_reg <= 1'b0;
      end else if (capture_strobe) begin
        capture_pend_valid_reg <= 1'b1;
      end else if (!freeze_now && capture_pend_valid_reg) begin
        preload_reg <= capture_pend_reg;
        capture_pend_valid_reg <= 1'b0;
      end
    end else begin
      read_frozen_reg <= 1'b0;
      capture_pend_valid_reg <= 1'b0;
      if (wr && i_address == tsync_pkg::OFF_CCRH) begin
        preload_reg[15:8] <= i_writedata[7:0];
        shadow_blocked_reg <= 1'b1;
      end else if (wr && i_address == tsync_pkg::OFF_CCRL) begin
        preload_reg[7:0] <= i_writedata[7:0];
        shadow_blocked_reg <= 1'b0;
      end else if (!shadow_blocked_reg) begin
        shadow_reg <= preload_reg;
      end
    end
  end

  // read mux; in input mode a low-only ccr read outside a sequence shows current count
  always_comb begin
    rdata_reg = 32'h0000_0000;
    unique case (i_address)
      tsync_pkg::OFF_CTRL: rdata_reg = {24'h0, 1'b0, master_select_field_reg, 2'h0,
                                        1'b0, counter_enable_bit_reg};
      tsync_pkg::OFF_SLAVE: rdata_reg = {24'h0, master_slave_align_bit_reg,
                                         trigger_source_select_reg, 1'b0,
                                         slave_behaviour_select_reg};
      tsync_pkg::OFF_STAT: rdata_reg = {29'h0, read_frozen_reg, shadow_blocked_reg,
                                        trigger_flag_reg};
      tsync_pkg::OFF_CNTH: rdata_reg = {24'h0, count_reg[15:8]};
      tsync_pkg::OFF_CNTL: rdata_reg = {24'h0, count_reg[7:0]};
      tsync_pkg::OFF_CCRH: rdata_reg = {24'h0, preload_reg[15:8]};
      tsync_pkg::OFF_CCRL: rdata_reg = (input_mode && !read_frozen_reg) ?
        {24'h0, count_reg[7:0]} : {24'h0, preload_reg[7:0]};
      tsync_pkg::OFF_CHAN: rdata_reg = {28'h0, capture_pend_valid_reg,
                                        compare1_reference_reg,
                                        channel_direction_select_reg};
      default: rdata_reg = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ack_reg <= 1'b0;
      o_readdata <= 32'h0000_0000;
    end else begin
      ack_reg <= o_waitrequest;
      if (rd) begin
        o_readdata <= rdata_reg;
      end
    end
  end

  // assertions
  a_update_pulse_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
    master_select_field_reg == tsync_pkg::MMS_UPDATE && update_event
    |=> o_trigger_output) else $error("update not on trigger output");
  a_update_pulse_end: assert property (@(posedge i_clk) disable iff (!i_resetn)
    master_select_field_reg == tsync_pkg::MMS_UPDATE && !update_event
    |=> !o_trigger_output) else $error("trigger pulse too long");
  a_enable_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
    master_select_field_reg == tsync_pkg::MMS_ENABLE |=>
    o_trigger_output == $past(count_enable_signal)) else $error("enable not driven");
  a_oc1_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
    master_select_field_reg == tsync_pkg::MMS_OC1 |=>
    o_trigger_output == $past(compare1_reference_reg)) else $error("oc1 not routed");
  a_gated_stop: assert property (@(posedge i_clk) disable iff (!i_resetn)
    slave_behaviour_select_reg == tsync_pkg::SMS_GATED && !trig_level && !wr && !ug_write
    |=> count_reg == $past(count_reg)) else $error("gated counter moved");
  a_gated_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
    slave_behaviour_select_reg == tsync_pkg::SMS_GATED && trig_level != trig_prev
    |=> trigger_flag_reg) else $error("gate change did not set flag");
  a_trigger_start: assert property (@(posedge i_clk) disable iff (!i_resetn)
    slave_behaviour_select_reg == tsync_pkg::SMS_TRIGGER && trig_rise
    |=> counter_enable_bit_reg && trigger_flag_reg) else $error("trigger start missed");
  a_ch1_start: assert property (@(posedge i_clk) disable iff (!i_resetn)
    slave_behaviour_select_reg == tsync_pkg::SMS_TRIGGER &&
    trigger_source_select_reg == tsync_pkg::TS_CH1 && ch1_sync_reg[1] && !ch1_prev_reg
    |=> counter_enable_bit_reg) else $error("channel 1 edge did not start counter");
  a_extclk_count: assert property (@(posedge i_clk) disable iff (!i_resetn)
    slave_behaviour_select_reg == tsync_pkg::SMS_EXTCLK && counter_enable_bit_reg &&
    trig_rise && !wr |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("external clock edge not counted");
  a_sync_delay: assert property (@(posedge i_clk) disable iff (!i_resetn)
    itr_sync_reg[1] |-> $past(i_internal_trigger_in, 2))
    else $error("trigger not two flops behind pin");
  a_align_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    master_slave_align_bit_reg && counter_enable_bit_reg && !count_enable_signal_dly_reg &&
    slave_behaviour_select_reg != tsync_pkg::SMS_EXTCLK && !wr
    |=> count_reg == $past(count_reg)) else $error("prescaler not held behind enable");
  a_ug_reset: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ug_write |=> count_reg == tsync_pkg::CNT_RST && psc_reg == 8'h00)
    else $error("update generate failed");
  sequence s_high_write;
    !input_mode && wr && i_address == tsync_pkg::OFF_CCRH;
  endsequence
  a_shadow_block: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_high_write ##1 (!wr && !input_mode) |=> shadow_reg == $past(shadow_reg))
    else $error("shadow updated while blocked");
  a_shadow_copy: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !input_mode && !shadow_blocked_reg && !wr |=> shadow_reg == $past(preload_reg))
    else $error("preload not copied to shadow");
  a_capture_shadow: assert property (@(posedge i_clk) disable iff (!i_resetn)
    capture_strobe |=> shadow_reg == $past(count_reg))
    else $error("capture missed shadow");
  a_read_freeze: assert property (@(posedge i_clk) disable iff (!i_resetn)
    input_mode && read_frozen_reg && !rd |=> preload_reg == $past(preload_reg))
    else $error("preload changed during read");
  a_low_read_count: assert property (@(posedge i_clk) disable iff (!i_resetn)
    input_mode && !read_frozen_reg && rd && i_address == tsync_pkg::OFF_CCRL
    |=> o_readdata[7:0] == $past(count_reg[7:0])) else $error("low read not live count");
endmodule

// ### tsync_pkg.sv
// package for timer synchronisation and capture/compare buffering
package tsync_pkg;
  // register byte offsets (avalon byte addresses, one word each)
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_SLAVE = 5'h04;
  localparam logic [4:0] OFF_STAT = 5'h08;
  localparam logic [4:0] OFF_CNTH = 5'h0c;
  localparam logic [4:0] OFF_CNTL = 5'h10;
  localparam logic [4:0] OFF_CCRH = 5'h14;
  localparam logic [4:0] OFF_CCRL = 5'h18;
  localparam logic [4:0] OFF_CHAN = 5'h1c;
  // ctrl fields
  localparam int CTRL_CEN = 0;
  localparam int CTRL_UG = 1;
  localparam int CTRL_MMS_LO = 4;
  // slave fields
  localparam int SLV_SMS_LO = 0;
  localparam int SLV_TS_LO = 4;
  localparam int SLV_MSM = 7;
  // status fields
  localparam int STAT_TIF = 0;
  localparam int STAT_BLK = 1;
  localparam int STAT_FRZ = 2;
  // channel fields
  localparam int CHAN_DIR_LO = 0;
  localparam int CHAN_OCREF = 2;
  localparam int CHAN_CAP = 3;
  // reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CCR_RST = 16'h0000;
  localparam logic [7:0] PSC_DIV_RST = 8'h03;
  // master select codes
  localparam logic [2:0] MMS_ENABLE = 3'h1;
  localparam logic [2:0] MMS_UPDATE = 3'h2;
  localparam logic [2:0] MMS_OC1 = 3'h4;
  // slave behaviour codes
  localparam logic [2:0] SMS_GATED = 3'h5;
  localparam logic [2:0] SMS_TRIGGER = 3'h6;
  localparam logic [2:0] SMS_EXTCLK = 3'h7;
  // trigger sources
  localparam logic [2:0] TS_INTERNAL = 3'h1;
  localparam logic [2:0] TS_CH1 = 3'h4;
  // channel direction
  localparam logic [1:0] DIR_OUTPUT = 2'h0;
endpackage

// ### tsync_peer_model.sv
// peer master timer model driving the internal trigger line
module tsync_peer_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // control from the bench
  input wire logic i_start,
  input wire logic [7:0] i_burst,
  input wire logic i_hold,
  // trigger towards the timer under test
  output logic o_trigger_output
);
  logic [7:0] left_reg;
  logic [1:0] div_reg;
  // one update event every four cycles while a burst lasts
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      left_reg <= 8'h00;
      div_reg <= 2'h0;
    end else if (i_start) begin
      left_reg <= i_burst;
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3 && left_reg != 8'h00) begin
        left_reg <= left_reg - 8'h01;
      end
    end
  end
  // level mode stands for an enable or compare reference; pulse mode for updates
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_trigger_output <= 1'b0;
    end else begin
      o_trigger_output <= i_hold | (div_reg == 2'h3 && left_reg != 8'h00);
    end
  end
endmodule

// ### testbench.sv
// self-checking bench for the timer sync and capture/compare block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [4:0] i_address = 5'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h00000000;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic i_channel1_input = 1'b0;
  logic o_trigger_output;
  logic o_compare_output;
  logic trig;
  logic p_start = 1'b0;
  logic [7:0] p_burst = 8'h00;
  logic p_hold = 1'b0;
  logic [31:0] rv;
  logic [15:0] cv;
  logic [15:0] cv2;
  int err_total = 0;
  int cmp_count = 0;

  // prescaler bypassed so each trigger edge or gated cycle moves the count by one
  tsync_timer #(.PSC_DIV(8'h00)) u_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_internal_trigger_in(trig),
    .i_channel1_input(i_channel1_input), .o_trigger_output(o_trigger_output),
    .o_compare_output(o_compare_output));
  tsync_peer_model u_peer (.i_clk(i_clk), .i_resetn(i_resetn), .i_start(p_start),
    .i_burst(p_burst), .i_hold(p_hold), .o_trigger_output(trig));

  initial begin
    forever #50 i_clk = ~i_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= {24'h000000, d};
    i_write <= wr;
    i_read <= ~wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    rv = o_readdata;
    chk(16'(n < 50), 16'h0001);
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({8'h00, rv[7:0] & m}, {8'h00, e});
  endtask

  // high byte always goes first
  task automatic wr16(input logic [4:0] a, input logic [15:0] v);
    bus(1'b1, a, v[15:8]);
    bus(1'b1, a + 5'h04, v[7:0]);
  endtask

  task automatic rcnt(output logic [15:0] v);
    bus(1'b0, tsync_pkg::OFF_CNTH, 8'h00);
    v[15:8] = rv[7:0];
    bus(1'b0, tsync_pkg::OFF_CNTL, 8'h00);
    v[7:0] = rv[7:0];
  endtask

  task automatic wait_trg(input logic v);
    int n;
    n = 0;
    while (o_trigger_output !== v && n < 30) begin
      @(posedge i_clk);
      n++;
    end
    chk({15'h0000, o_trigger_output}, {15'h0000, v});
  endtask

  task automatic peer(input logic [7:0] b);
    @(posedge i_clk);
    p_start <= 1'b1;
    p_burst <= b;
    @(posedge i_clk);
    p_start <= 1'b0;
  endtask

  task automatic ch1_pulse();
    @(posedge i_clk);
    i_channel1_input <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_channel1_input <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(tsync_pkg::OFF_CNTH, 8'hff, 8'h00);
    rd(tsync_pkg::OFF_CCRL, 8'hff, 8'h00);
    rd(5'h02, 8'hff, 8'h00);
    chk({15'h0000, o_trigger_output}, 16'h0000);
    done("reset");
    wr16(tsync_pkg::OFF_CNTH, 16'h12e7);
    rd(tsync_pkg::OFF_CNTH, 8'hff, 8'h12);
    rd(tsync_pkg::OFF_CNTL, 8'hff, 8'he7);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h02);
    rcnt(cv);
    chk(cv, 16'h0000);
    rd(tsync_pkg::OFF_CTRL, 8'h02, 8'h00);
    done("counter");
    bus(1'b1, tsync_pkg::OFF_CHAN, 8'h00);
    bus(1'b1, tsync_pkg::OFF_CCRH, 8'hab);
    rd(tsync_pkg::OFF_STAT, 8'h02, 8'h02);
    bus(1'b1, tsync_pkg::OFF_CCRL, 8'hcd);
    rd(tsync_pkg::OFF_STAT, 8'h02, 8'h00);
    rd(tsync_pkg::OFF_CCRH, 8'hff, 8'hab);
    rd(tsync_pkg::OFF_CCRL, 8'hff, 8'hcd);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h42);
    wait_trg(1'b1);
    rd(tsync_pkg::OFF_CHAN, 8'h04, 8'h04);
    chk({15'h0000, o_compare_output}, 16'h0001);
    wr16(tsync_pkg::OFF_CCRH, 16'h0000);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h42);
    wait_trg(1'b0);
    done("compare");
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h11);
    wait_trg(1'b1);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h10);
    wait_trg(1'b0);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h20);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h22);
    wait_trg(1'b1);
    @(posedge i_clk);
    chk({15'h0000, o_trigger_output}, 16'h0000);
    done("master");
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h00);
    bus(1'b1, tsync_pkg::OFF_SLAVE, 8'h17);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h03);
    peer(8'h05);
    repeat (40) @(posedge i_clk);
    rcnt(cv);
    chk(cv, 16'h0005);
    done("external clock");
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h00);
    bus(1'b1, tsync_pkg::OFF_SLAVE, 8'h15);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h03);
    rcnt(cv);
    chk(cv, 16'h0000);
    p_hold <= 1'b1;
    repeat (20) @(posedge i_clk);
    p_hold <= 1'b0;
    repeat (10) @(posedge i_clk);
    rcnt(cv);
    chk(cv, 16'h0014);
    rcnt(cv2);
    chk(cv2, cv);
    done("gated");
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h00);
    bus(1'b1, tsync_pkg::OFF_STAT, 8'h00);
    bus(1'b1, tsync_pkg::OFF_SLAVE, 8'h16);
    rd(tsync_pkg::OFF_CTRL, 8'h01, 8'h00);
    peer(8'h01);
    repeat (12) @(posedge i_clk);
    rd(tsync_pkg::OFF_CTRL, 8'h01, 8'h01);
    rd(tsync_pkg::OFF_STAT, 8'h01, 8'h01);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h00);
    rcnt(cv);
    rcnt(cv2);
    chk(cv2, cv);
    done("trigger start");
    bus(1'b1, tsync_pkg::OFF_STAT, 8'h00);
    bus(1'b1, tsync_pkg::OFF_SLAVE, 8'h46);
    ch1_pulse();
    rd(tsync_pkg::OFF_CTRL, 8'h01, 8'h01);
    rd(tsync_pkg::OFF_STAT, 8'h01, 8'h01);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h00);
    done("channel trigger");
    bus(1'b1, tsync_pkg::OFF_SLAVE, 8'h00);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h03);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h00);
    rcnt(cv);
    chk(cv, 16'h0003);
    bus(1'b1, tsync_pkg::OFF_SLAVE, 8'h80);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h03);
    bus(1'b1, tsync_pkg::OFF_CTRL, 8'h00);
    rcnt(cv2);
    chk(cv2, 16'h0002);
    done("align");
    bus(1'b1, tsync_pkg::OFF_SLAVE, 8'h00);
    bus(1'b1, tsync_pkg::OFF_CHAN, 8'h01);
    wr16(tsync_pkg::OFF_CNTH, 16'h1234);
    ch1_pulse();
    rd(tsync_pkg::OFF_CCRH, 8'hff, 8'h12);
    rd(tsync_pkg::OFF_STAT, 8'h04, 8'h04);
    wr16(tsync_pkg::OFF_CNTH, 16'h5678);
    ch1_pulse();
    rd(tsync_pkg::OFF_CCRL, 8'hff, 8'h34);
    rd(tsync_pkg::OFF_STAT, 8'h04, 8'h00);
    rd(tsync_pkg::OFF_CCRH, 8'hff, 8'h56);
    rd(tsync_pkg::OFF_CCRL, 8'hff, 8'h78);
    wr16(tsync_pkg::OFF_CNTH, 16'h0099);
    rd(tsync_pkg::OFF_CCRL, 8'hff, 8'h99);
    done("capture");
    summarize();
  end

  // whole run needs a few hundred cycles
  initial begin
    repeat (30000) @(posedge i_clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
endmodule
